/* File: hdl/segment_select_and_flags.sv */
// Contract
// RULE1 - real/v86: base shifted four plus offset
// RULE2 - linear is physical unless v86 paging; the code never translates, physical always equals linear
// RULE3 - protected selector: index, table bit, privilege
// RULE4 - index picks descriptor giving base, limit, access
// RULE5 - table bit zero global, one local
// RULE6 - effective privilege is less privileged of two
// RULE7 - segment load caches descriptor in hidden part
// RULE8 - no override for fetch, stack, string store
// RULE9 - fetch code, stack ops stack, store extra
// RULE10 - data defaults by base register, overridable
// RULE11 - pointer advances unless transfer loads it
// RULE12 - carry from top bit sets bit 0
// RULE13 - even low-byte parity sets bit 2
// RULE14 - carry out of bit 3 sets bit 4
// RULE15 - zero sets bit 6, bit 7 copies sign
// RULE16 - overflow is carry-in xor carry-out of sign
// RULE17 - trap bit raises single step, cleared by it
// RULE18 - maskable pin served only with bit 9
// RULE19 - bit 10 selects string index direction
// RULE20 - io privilege gates io and interrupt flag
// RULE21 - resume bit suppresses next debug fault
// RULE22 - bit 17 enters v86, set at privilege 0
//
// Added by the designer: the placing of the registers and register access over APB.
`include "seg_flags_map.svh"
module segment_select_and_flags
  import seg_flags_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic              maskable_irq_pin,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq_ack,
  output logic                   single_step_irq,
  output logic                   io_allowed
);

  //////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0] sel [6];
  hidden_t     hidden [6];
  logic [5:0]  seg_wr_vec;
  logic [31:0] next_instr_offset;
  logic [31:0] processor_flags_word;
  logic [31:0] next_flags;
  ctrl_t       ctrl;
  logic [31:0] desc_lo;
  logic [31:0] desc_hi;
  logic [31:0] gdt_base;
  logic [31:0] ldt_base;
  mem_ref_t    mref;
  logic [31:0] ref_off;
  logic [31:0] alu_a;
  logic [31:0] alu_b;
  logic [31:0] alu_res;
  logic [31:0] jump_target;
  logic [31:0] string_source_index;
  logic [31:0] string_dest_index;
  logic [31:0] desc_fetch_addr;
  logic [1:0]  effective_privilege;
  logic        table_choice_bit;
  logic        dbg_suppress;
  logic        irq_s1;
  logic        irq_s2;
  logic [31:0] rd_val;
  logic        rd_err;

  //////////////////////////////////////////////////////////////////////////
  // bus decode: zero wait state, data prepared in the setup cycle
  wire setup   = psel && !penable;
  wire wr_en   = psel && penable && pwrite && pready;
  wire [7:0] a = 8'(paddr);
  wire flags_wr = wr_en && a == `OFF_FLAGS;
  wire alu_wr   = wr_en && a == `OFF_ALU_OP;
  wire step_wr  = wr_en && a == `OFF_STEP;
  wire any_seg_wr = |seg_wr_vec;

  //////////////////////////////////////////////////////////////////////////
  // operating mode
  wire       v86_mode    = ctrl.pe && processor_flags_word[`FLAG_VM];
  wire       real_style  = !ctrl.pe || v86_mode;            // [RULE22]
  wire       translate   = ctrl.pe && ctrl.pg;
  wire [1:0] io_privilege_level_field        = processor_flags_word[`FLAG_IO_PRIVILEGE_LEVEL_FIELD+1:`FLAG_IO_PRIVILEGE_LEVEL_FIELD];

  //////////////////////////////////////////////////////////////////////////
  // selector fields of the value being loaded
  wire [12:0] sel_index = pwdata[15:3];                     // [RULE3]
  wire        sel_ti    = pwdata[2];
  wire [1:0]  sel_rpl   = pwdata[1:0];
  wire [31:0] tbl_base  = sel_ti ? ldt_base : gdt_base;     // [RULE5]
  wire [31:0] fetch_next = tbl_base + {16'h0000, sel_index, 3'b000}; // [RULE4]
  wire [1:0]  epl_next  = (sel_rpl > ctrl.current_privilege) ? sel_rpl : ctrl.current_privilege; // [RULE6]

  // hidden part built from the descriptor or from the real-style value
  wire hidden_t desc_h = '{
    base:   {desc_hi[31:24], desc_hi[7:0], desc_lo[31:16]},
    limit:  {desc_hi[19:16], desc_lo[15:0]},
    access: desc_hi[15:8]};                                  // [RULE4]
  wire hidden_t real_h = '{
    base:   {12'h000, pwdata[15:0], 4'h0},
    limit:  `LIMIT_REAL,
    access: `ACCESS_REAL};
  localparam hidden_t HID_RST = '{32'h0, `LIMIT_REAL, `ACCESS_REAL};

  //////////////////////////////////////////////////////////////////////////
  // six segment registers with their hidden caches
  for (genvar g = 0; g < 6; g++)
  begin : g_seg
    localparam logic [15:0] SEL_RST = (g == 1) ? `CS_RESET : 16'h0000;
    assign seg_wr_vec[g] = wr_en && a == (`OFF_SEG0 + 8'(4 * g));
    // cache is written only by a load of this register
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        sel[g]    <= SEL_RST;
        hidden[g] <= HID_RST;
      end
      else if (seg_wr_vec[g])
      begin
        sel[g]    <= pwdata[15:0];
        hidden[g] <= real_style ? real_h : desc_h;           // [RULE7]
      end
    end
  end

  // load side effects: table fetch address and effective privilege
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      desc_fetch_addr     <= 32'h0000_0000;
      effective_privilege <= 2'h0;
      table_choice_bit    <= 1'b0;
    end
    else if (any_seg_wr && !real_style)
    begin
      desc_fetch_addr     <= fetch_next;                     // [RULE5]
      effective_privilege <= epl_next;                       // [RULE6]
      table_choice_bit    <= sel_ti;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // default segment choice for the posted memory reference
  wire via_stack = mref.base_reg == 3'h4 || mref.base_reg == 3'h5;
  wire ovr_ok    = mref.ovr_valid && mref.ovr_seg <= seg_gs;
  wire seg_idx_t data_seg = ovr_ok ? mref.ovr_seg :
                            (via_stack ? seg_ss : seg_ds);   // [RULE10]
  wire is_stack  = mref.kind == ref_push || mref.kind == ref_pop;
  wire seg_idx_t seg_choice =
    (mref.kind == ref_code)     ? seg_cs :
    is_stack                    ? seg_ss :
    (mref.kind == ref_str_dest) ? seg_es : data_seg;         // [RULE8] [RULE9]

  // address formation
  wire [31:0] off_eff  = ctrl.addr32 ? ref_off : {16'h0000, ref_off[15:0]};
  wire [31:0] real_base = {12'h000, sel[seg_choice], 4'h0};
  wire [31:0] seg_base = real_style ? real_base
                                    : hidden[seg_choice].base; // [RULE4]
  wire [31:0] lin_addr = seg_base + off_eff;                 // [RULE1]
  wire [31:0] phys_addr = lin_addr;                          // [RULE2]

  //////////////////////////////////////////////////////////////////////////
  // adder feeding the arithmetic flags
  wire        alu_sub = pwdata[0];
  wire [31:0] b_eff   = alu_sub ? ~alu_b : alu_b;
  wire [32:0] sum     = {1'b0, alu_a} + {1'b0, b_eff} + {32'h0, alu_sub};
  wire [31:0] res     = sum[31:0];
  wire        c_out   = sum[32];
  wire        c_in31  = alu_a[31] ^ b_eff[31] ^ res[31];
  wire        new_cf  = c_out ^ alu_sub;                     // [RULE12]
  wire        new_pf  = ~^res[7:0];                          // [RULE13]
  wire        new_af  = alu_a[4] ^ alu_b[4] ^ res[4];        // [RULE14]
  wire        new_zf  = res == 32'h0;                        // [RULE15]
  wire        new_of  = c_in31 ^ c_out;                      // [RULE16]

  // value written by software, gated by privilege
  wire        if_locked = ctrl.pe && ctrl.current_privilege > io_privilege_level_field;
  wire        vm_open   = ctrl.pe && ctrl.current_privilege == 2'h0;
  wire [31:0] pop_raw   = (pwdata & `FLAGS_WMASK) | `FLAGS_RESET;

  // flags next state
  always_comb
  begin
    next_flags = processor_flags_word;
    if (flags_wr)
    begin
      next_flags = pop_raw;
      if (if_locked)
        next_flags[`FLAG_IF] = processor_flags_word[`FLAG_IF]; // [RULE20]
      if (!vm_open)
        next_flags[`FLAG_VM] = processor_flags_word[`FLAG_VM]; // [RULE22]
    end
    else if (alu_wr)
    begin
      next_flags[`FLAG_CF] = new_cf;
      next_flags[`FLAG_PF] = new_pf;
      next_flags[`FLAG_AF] = new_af;
      next_flags[`FLAG_ZF] = new_zf;
      next_flags[`FLAG_SF] = res[31];                        // [RULE15]
      next_flags[`FLAG_OF] = new_of;
    end
    else if (step_wr)
    begin
      next_flags[`FLAG_RF] = 1'b0;                           // [RULE21]
      if (pwdata[5])
        next_flags[`FLAG_TF] = 1'b0;                         // [RULE17]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // instruction step: pointer, trap, resume, string indices
  wire step_t      st      = step_t'(pwdata[8:0]);
  wire [31:0]      stride  = 32'h1 << st.size;
  wire             dir_dn  = processor_flags_word[`FLAG_DF];
  wire [31:0] src_next = dir_dn ? string_source_index - stride
                                : string_source_index + stride; // [RULE19]
  wire [31:0] dst_next = dir_dn ? string_dest_index - stride
                                : string_dest_index + stride;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      next_instr_offset    <= `IP_RESET;
      processor_flags_word <= `FLAGS_RESET;
      single_step_irq      <= 1'b0;
      dbg_suppress         <= 1'b0;
    end
    else
    begin
      processor_flags_word <= next_flags;
      if (wr_en && a == `OFF_IP)
        next_instr_offset <= pwdata;
      else if (step_wr)
      begin
        if (st.take_int || st.jump)
          next_instr_offset <= jump_target;                  // [RULE11]
        else
          next_instr_offset <= next_instr_offset + {28'h0, st.len};
        dbg_suppress <= processor_flags_word[`FLAG_RF];      // [RULE21]
        if (st.take_int)
          single_step_irq <= 1'b0;                           // [RULE17]
        else if (processor_flags_word[`FLAG_TF])
          single_step_irq <= 1'b1;
      end
    end
  end

  // string index registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      string_source_index <= 32'h0;
      string_dest_index   <= 32'h0;
    end
    else if (wr_en && a == `OFF_SRC_IDX)
      string_source_index <= pwdata;
    else if (wr_en && a == `OFF_DST_IDX)
      string_dest_index <= pwdata;
    else if (step_wr && st.string_op && !st.take_int)
    begin
      string_source_index <= src_next;                       // [RULE19]
      string_dest_index   <= dst_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // plain software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= '0; desc_lo <= 32'h0; desc_hi <= 32'h0;
      gdt_base <= 32'h0; ldt_base <= 32'h0; mref <= '0;
      ref_off <= 32'h0; alu_a <= 32'h0; alu_b <= 32'h0;
      alu_res <= 32'h0; jump_target <= 32'h0;
    end
    else if (wr_en)
    begin
      if (a == `OFF_CTRL)          ctrl <= ctrl_t'(pwdata[4:0]);
      else if (a == `OFF_DESC_LO)  desc_lo <= pwdata;
      else if (a == `OFF_DESC_HI)  desc_hi <= pwdata;
      else if (a == `OFF_GDT_BASE) gdt_base <= pwdata;
      else if (a == `OFF_LDT_BASE) ldt_base <= pwdata;
      else if (a == `OFF_REF)      mref <= mem_ref_t'(pwdata[9:0]);
      else if (a == `OFF_REF_OFF)  ref_off <= pwdata;
      else if (a == `OFF_ALU_A)    alu_a <= pwdata;
      else if (a == `OFF_ALU_B)    alu_b <= pwdata;
      else if (a == `OFF_ALU_OP)   alu_res <= res;
      else if (a == `OFF_TARGET)   jump_target <= pwdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // maskable pin synchroniser, acknowledge and io permission
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_s1     <= 1'b0;
      irq_s2     <= 1'b0;
      irq_ack    <= 1'b0;
      io_allowed <= 1'b1;
    end
    else
    begin
      irq_s1     <= maskable_irq_pin;
      irq_s2     <= irq_s1;
      irq_ack    <= irq_s2 && processor_flags_word[`FLAG_IF]; // [RULE18]
      io_allowed <= !ctrl.pe || ctrl.current_privilege <= io_privilege_level_field;            // [RULE20]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux
  wire [31:0] status = {19'h0, seg_choice, irq_s2, table_choice_bit,
                        effective_privilege, irq_ack, dbg_suppress,
                        single_step_irq, io_allowed, translate, v86_mode};
  always_comb
  begin
    rd_val = 32'h0;
    rd_err = 1'b0;
    if (a < `OFF_IP && a[1:0] == 2'b00)
      rd_val = {16'h0, sel[a[4:2]]};
    else if (a == `OFF_IP)       rd_val = next_instr_offset;
    else if (a == `OFF_FLAGS)    rd_val = processor_flags_word;
    else if (a == `OFF_CTRL)     rd_val = {27'h0, ctrl};
    else if (a == `OFF_DESC_LO)  rd_val = desc_lo;
    else if (a == `OFF_DESC_HI)  rd_val = desc_hi;
    else if (a == `OFF_GDT_BASE) rd_val = gdt_base;
    else if (a == `OFF_LDT_BASE) rd_val = ldt_base;
    else if (a == `OFF_REF)      rd_val = {22'h0, mref};
    else if (a == `OFF_REF_OFF)  rd_val = ref_off;
    else if (a == `OFF_LINEAR)   rd_val = lin_addr;
    else if (a == `OFF_PHYS)     rd_val = phys_addr;
    else if (a == `OFF_STATUS)   rd_val = status;
    else if (a == `OFF_ALU_A)    rd_val = alu_a;
    else if (a == `OFF_ALU_B)    rd_val = alu_b;
    else if (a == `OFF_ALU_OP)   rd_val = 32'h0;
    else if (a == `OFF_ALU_RES)  rd_val = alu_res;
    else if (a == `OFF_STEP)     rd_val = 32'h0;
    else if (a == `OFF_TARGET)   rd_val = jump_target;
    else if (a == `OFF_SRC_IDX)  rd_val = string_source_index;
    else if (a == `OFF_DST_IDX)  rd_val = string_dest_index;
    else if (a == `OFF_FETCH)    rd_val = desc_fetch_addr;
    else if (a == `OFF_SEG_BASE) rd_val = seg_base;
    else                         rd_err = 1'b1;
  end

  // answer registered in the setup cycle, ready in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (setup)
      begin
        prdata  <= pwrite ? 32'h0 : rd_val;
        pslverr <= rd_err || (pwrite && a[1:0] != 2'b00);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_real_form;
    real_style |-> lin_addr == real_base + off_eff;
  endproperty
  a_real_form: assert property (p_real_form) // [RULE1]
    else $error("real-style linear address wrong");

  property p_fetch_addr;
    (any_seg_wr && !real_style) |=>
      desc_fetch_addr == ($past(pwdata[2]) ? $past(ldt_base)
        : $past(gdt_base)) + {16'h0, $past(pwdata[15:3]), 3'b000};
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) // [RULE5]
    else $error("descriptor fetch address wrong");

  property p_epl;
    (any_seg_wr && !real_style) |=> effective_privilege >= $past(ctrl.current_privilege)
      && effective_privilege >= $past(pwdata[1:0]);
  endproperty
  a_epl: assert property (p_epl) // [RULE6]
    else $error("effective privilege too privileged");

  property p_hidden_hold;
    !seg_wr_vec[3] |=> $stable(hidden[3]);
  endproperty
  a_hidden_hold: assert property (p_hidden_hold) // [RULE7]
    else $error("hidden cache changed without a load");

  property p_fixed_seg;
    mref.kind != ref_data |-> seg_choice == (mref.kind == ref_code ? seg_cs
      : mref.kind == ref_str_dest ? seg_es : seg_ss);
  endproperty
  a_fixed_seg: assert property (p_fixed_seg) // [RULE8]
    else $error("override leaked into fixed segment");

  property p_data_default;
    (mref.kind == ref_data && !mref.ovr_valid) |->
      seg_choice == (mref.base_reg[2:1] == 2'b10 ? seg_ss : seg_ds);
  endproperty
  a_data_default: assert property (p_data_default) // [RULE10]
    else $error("data default segment wrong");

  property p_ip_adv;
    (step_wr && !pwdata[5] && !pwdata[4]) |=>
      next_instr_offset ==
        $past(next_instr_offset) + {28'h0, $past(pwdata[3:0])};
  endproperty
  a_ip_adv: assert property (p_ip_adv) // [RULE11]
    else $error("instruction pointer did not advance");

  property p_carry;
    alu_wr |=> processor_flags_word[`FLAG_CF] == $past(c_out ^ alu_sub)
      && processor_flags_word[`FLAG_ZF] == ($past(res) == 32'h0);
  endproperty
  a_carry: assert property (p_carry) // [RULE12]
    else $error("carry or zero flag wrong");

  property p_trap;
    (step_wr && !pwdata[5] && processor_flags_word[`FLAG_TF]) |=>
      single_step_irq [*2];
  endproperty
  a_trap: assert property (p_trap) // [RULE17]
    else $error("single step not raised");

  property p_irq_gate;
    irq_ack |-> $past(processor_flags_word[`FLAG_IF]) && $past(irq_s2);
  endproperty
  a_irq_gate: assert property (p_irq_gate) // [RULE18]
    else $error("interrupt acknowledged while masked");

  property p_if_lock;
    (flags_wr && if_locked) |=> $stable(processor_flags_word[`FLAG_IF]);
  endproperty
  a_if_lock: assert property (p_if_lock) // [RULE20]
    else $error("interrupt flag changed without privilege");

  property p_vm_lock;
    (flags_wr && !vm_open) |=> $stable(processor_flags_word[`FLAG_VM]);
  endproperty
  a_vm_lock: assert property (p_vm_lock) // [RULE22]
    else $error("virtual mode bit changed off privilege 0");

  c_prot_load: cover property (any_seg_wr && !real_style && sel_ti);
  c_override:  cover property (mref.kind == ref_data && ovr_ok);
  c_trap_step: cover property (step_wr && processor_flags_word[`FLAG_TF]);
  c_irq:       cover property (irq_ack);

endmodule

/* File: hdl/seg_flags_map.svh */
`ifndef SEG_FLAGS_MAP_SVH
`define SEG_FLAGS_MAP_SVH
// register byte offsets
`define OFF_SEG0      8'h00
`define OFF_IP        8'h18
`define OFF_FLAGS     8'h1c
`define OFF_CTRL      8'h20
`define OFF_DESC_LO   8'h24
`define OFF_DESC_HI   8'h28
`define OFF_GDT_BASE  8'h2c
`define OFF_LDT_BASE  8'h30
`define OFF_REF       8'h34
`define OFF_REF_OFF   8'h38
`define OFF_LINEAR    8'h3c
`define OFF_PHYS      8'h40
`define OFF_STATUS    8'h44
`define OFF_ALU_A     8'h48
`define OFF_ALU_B     8'h4c
`define OFF_ALU_OP    8'h50
`define OFF_ALU_RES   8'h54
`define OFF_STEP      8'h58
`define OFF_TARGET    8'h5c
`define OFF_SRC_IDX   8'h60
`define OFF_DST_IDX   8'h64
`define OFF_FETCH     8'h68
`define OFF_SEG_BASE  8'h6c
// flags word bit positions
`define FLAG_CF   0
`define FLAG_PF   2
`define FLAG_AF   4
`define FLAG_ZF   6
`define FLAG_SF   7
`define FLAG_TF   8
`define FLAG_IF   9
`define FLAG_DF   10
`define FLAG_OF   11
`define FLAG_IO_PRIVILEGE_LEVEL_FIELD 12
`define FLAG_RF   16
`define FLAG_VM   17
// reset values and masks
`define FLAGS_RESET  32'h0000_0002
`define FLAGS_WMASK  32'h0007_7fd5
`define IP_RESET     32'h0000_fff0
`define CS_RESET     16'hf000
`define LIMIT_REAL   20'h0_ffff
`define ACCESS_REAL  8'h93
`endif

/* File: hdl/seg_flags_pkg.sv */
package seg_flags_pkg;
  typedef enum logic [2:0] {
    seg_es, seg_cs, seg_ss, seg_ds, seg_fs, seg_gs
  } seg_idx_t;
  typedef enum logic [2:0] {
    ref_code, ref_push, ref_pop, ref_str_dest, ref_data
  } ref_kind_t;
  typedef struct packed {
    logic [31:0] base;
    logic [19:0] limit;
    logic [7:0]  access;
  } hidden_t;
  typedef struct packed {
    logic [1:0] current_privilege;
    logic       addr32;
    logic       pg;
    logic       pe;
  } ctrl_t;
  typedef struct packed {
    logic [2:0] base_reg;
    logic       ovr_valid;
    seg_idx_t   ovr_seg;
    ref_kind_t  kind;
  } mem_ref_t;
  typedef struct packed {
    logic [1:0] size;
    logic       string_op;
    logic       take_int;
    logic       jump;
    logic [3:0] len;
  } step_t;
endpackage

/* File: dv/tb.sv */
`include "seg_flags_map.svh"
module tb
  import seg_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] SEG_CODE = 8'h04;
  localparam logic [7:0] SEG_DATA = 8'h0c;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        maskable_irq_pin;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_ack;
  logic        single_step_irq;
  logic        io_allowed;
  logic        last_err;
  int          miscompares;
  int          n_checks;

  segment_select_and_flags u_segment_select_and_flags (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .maskable_irq_pin(maskable_irq_pin), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_ack(irq_ack),
    .single_step_irq(single_step_irq), .io_allowed(io_allowed)
  );

  // 200 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  //////////////////////////////////////////////////////////////////////////
  // compare, verdict and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one apb transfer: hold the request until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    r = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      miscompares++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    @(negedge pclk);
    chk({31'h0, io_allowed}, 32'h1);
    rd(SEG_CODE, '1, 32'h0000_f000);
    rd(`OFF_IP, '1, 32'h0000_fff0);
    rd(`OFF_FLAGS, '1, 32'h0000_0002);
    rd(8'hfc, '1, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_real();
    wr(SEG_DATA, 32'h1234);
    wr(`OFF_REF, 32'h4);
    wr(`OFF_REF_OFF, 32'h0001_0010);
    rd(`OFF_LINEAR, '1, 32'h0001_2350);
    rd(`OFF_PHYS, '1, 32'h0001_2350);
    wr(`OFF_CTRL, 32'h4);
    rd(`OFF_LINEAR, '1, 32'h0002_2350);
    wr(`OFF_CTRL, 32'h0);
    $display("test real done");
  endtask

  // reference kind, override and base register against chosen segment
  task automatic t_segsel();
    logic [31:0] refs [10] = '{32'h58, 32'h61, 32'h2, 32'h6b, 32'h284,
                               32'h204, 32'h304, 32'h4, 32'h2cc, 32'h1ec};
    logic [2:0]  segs [10] = '{1, 2, 2, 0, 2, 2, 3, 3, 1, 5};
    for (int i = 0; i < 10; i++)
    begin
      wr(`OFF_REF, refs[i]);
      rd(`OFF_STATUS, 32'h1c00, 32'(segs[i])<<10);
    end
    $display("test segment choice done");
  endtask

  task automatic t_alu();
    logic [31:0] a [5] = '{32'hffff_ffff, 32'h7fff_ffff, 0, 1, 32'h8000_0000};
    logic [31:0] b [5] = '{1, 1, 1, 2, 1};
    logic [31:0] s [5] = '{0, 0, 1, 0, 1};
    logic [31:0] q [5] = '{0, 32'h8000_0000, '1, 3, 32'h7fff_ffff};
    logic [31:0] f [5] = '{32'h55, 32'h894, 32'h95, 32'h4, 32'h814};
    for (int i = 0; i < 5; i++)
    begin
      wr(`OFF_ALU_A, a[i]);
      wr(`OFF_ALU_B, b[i]);
      wr(`OFF_ALU_OP, s[i]);
      rd(`OFF_ALU_RES, '1, q[i]);
      rd(`OFF_FLAGS, 32'h8d5, f[i]);
      rd(`OFF_FLAGS, 32'h8d5, f[i]);
    end
    $display("test alu flags done");
  endtask

  task automatic t_irq();
    int n;
    wr(`OFF_FLAGS, 32'h0);
    maskable_irq_pin <= 1'b1;
    repeat (8)
    begin
      @(negedge pclk);
      chk({31'h0, irq_ack}, 32'h0);
    end
    wr(`OFF_FLAGS, 32'h200);
    n = 0;
    while (irq_ack !== 1'b1 && n < 10)
    begin
      @(negedge pclk);
      n++;
    end
    chk({31'h0, irq_ack}, 32'h1);
    if (n >= 10)
      give_verdict();
    wr(`OFF_FLAGS, 32'h0);
    repeat (3) @(negedge pclk);
    chk({31'h0, irq_ack}, 32'h0);
    maskable_irq_pin <= 1'b0;
    $display("test irq done");
  endtask

  task automatic t_step();
    wr(`OFF_IP, 32'h100);
    wr(`OFF_STEP, 32'h3);
    rd(`OFF_IP, '1, 32'h103);
    wr(`OFF_TARGET, 32'h2000);
    wr(`OFF_STEP, 32'h13);
    rd(`OFF_IP, '1, 32'h2000);
    wr(`OFF_FLAGS, 32'h100);
    wr(`OFF_STEP, 32'h1);
    @(negedge pclk);
    chk({31'h0, single_step_irq}, 32'h1);
    wr(`OFF_STEP, 32'h20);
    rd(`OFF_FLAGS, 32'h100, 32'h0);
    chk({31'h0, single_step_irq}, 32'h0);
    wr(`OFF_FLAGS, 32'h1_0000);
    wr(`OFF_STEP, 32'h1);
    rd(`OFF_STATUS, 32'h10, 32'h10);
    rd(`OFF_FLAGS, 32'h1_0000, 32'h0);
    wr(`OFF_SRC_IDX, 32'h100);
    wr(`OFF_DST_IDX, 32'h200);
    wr(`OFF_STEP, 32'h141);
    rd(`OFF_DST_IDX, '1, 32'h204);
    wr(`OFF_FLAGS, 32'h400);
    wr(`OFF_STEP, 32'h41);
    rd(`OFF_SRC_IDX, '1, 32'h103);
    $display("test step done");
  endtask

  task automatic t_prot();
    wr(`OFF_CTRL, 32'h09);
    wr(`OFF_GDT_BASE, 32'h1000);
    wr(`OFF_LDT_BASE, 32'h2000);
    wr(`OFF_DESC_LO, 32'h5678_ffff);
    wr(`OFF_DESC_HI, 32'h12cf_9334);
    wr(`OFF_REF, 32'h4);
    wr(`OFF_REF_OFF, 32'h10);
    wr(SEG_DATA, 32'h2f);
    rd(`OFF_FETCH, '1, 32'h2028);
    rd(`OFF_STATUS, 32'h1c0, 32'h1c0);
    rd(`OFF_LINEAR, '1, 32'h1234_5688);
    wr(`OFF_DESC_HI, 32'h0);
    rd(`OFF_SEG_BASE, '1, 32'h1234_5678);
    wr(SEG_DATA, 32'h10);
    rd(`OFF_FETCH, '1, 32'h1010);
    rd(`OFF_STATUS, 32'h1c0, 32'h040);
    $display("test protected done");
  endtask

  // privilege gating of io, interrupt enable and mode switch
  task automatic t_priv();
    wr(`OFF_CTRL, 32'h19);
    wr(`OFF_FLAGS, 32'h200);
    rd(`OFF_FLAGS, 32'h3200, 32'h0);
    chk({31'h0, io_allowed}, 32'h0);
    wr(`OFF_FLAGS, 32'h3000);
    wr(`OFF_FLAGS, 32'h3200);
    rd(`OFF_FLAGS, 32'h3200, 32'h3200);
    chk({31'h0, io_allowed}, 32'h1);
    wr(`OFF_FLAGS, 32'h2_0000);
    rd(`OFF_FLAGS, 32'h2_0000, 32'h0);
    wr(`OFF_CTRL, 32'h03);
    wr(`OFF_FLAGS, 32'h2_0000);
    rd(`OFF_STATUS, 32'h3, 32'h3);
    wr(SEG_DATA, 32'h1234);
    rd(`OFF_LINEAR, '1, 32'h0001_2350);
    $display("test privilege done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {psel, penable, pwrite, maskable_irq_pin, presetn, last_err} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_real();
    t_segsel();
    t_alu();
    t_irq();
    t_step();
    t_prot();
    t_priv();
    give_verdict();
  end
endmodule
